// ==== include/spimad_pkg.sv ====
package spimad_pkg;
   // ==========================================
   // Command byte layout
   localparam int CMD_OP_MSB = 7;
   localparam int CMD_OP_LSB = 3;
   localparam logic [4:0] OP_SEQ_WR = 5'h03;
   localparam logic [4:0] OP_SEQ_RD = 5'h07;
   localparam logic [4:0] OP_RND_WR = 5'h01;
   localparam logic [4:0] OP_RND_RD = 5'h05;
   localparam logic [7:0] DUMMY_BYTE_CMD = 8'hFF;
   localparam logic [2:0] PROG_RAM_HI = 3'h6;
   // ==========================================
   // Geometry and status
   localparam int ADDR_W = 11;
   localparam int BYTE_W = 8;
   localparam int STATUS_READY_BIT = 7;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] SYNC_RST = 3'h7;
   // ==========================================
   // Decoder states
   typedef enum logic [7:0] {
      SPIMAD_IDLE    = 8'h01,
      SPIMAD_ADDR    = 8'h02,
      SPIMAD_SEQ_WR  = 8'h04,
      SPIMAD_SEQ_RD  = 8'h08,
      SPIMAD_RW_ADDR = 8'h10,
      SPIMAD_RW_DATA = 8'h20,
      SPIMAD_RND_RD  = 8'h40,
      SPIMAD_IGNORE  = 8'h80
   } spimad_state_t;
   typedef enum logic [1:0] {
      SPIMAD_K_SEQ_WR = 2'h0,
      SPIMAD_K_SEQ_RD = 2'h1,
      SPIMAD_K_RND_WR = 2'h2,
      SPIMAD_K_RND_RD = 2'h3
   } spimad_kind_t;
endpackage

// ==== logic/spimad_top.sv ====
`timescale 1ns/1ps
// Function
// - Command low three bits give address 10:8, next byte gives address 7:0.
// - Sequential write codes 0x18 packet, 0x19 backup, 0x1B modem configuration.
// - Sequential read codes 0x38, 0x39, 0x3B, then address then dummy bytes.
// - Random write: pairs of low address and data, written in same block.
// - Random read: addresses then two dummies; data returns two bytes later.
// - Sequential read: first byte after address is meaningless, second holds data.
// - Sequential read advances address by one per further dummy byte.
// - Program RAM written only by sequential write 0x1E; no other access.
// - Byte 0xFF is a no-operation; only status returns.
// - Single sequential read returns data during the fourth byte.
// - Sequential write increments address after each data byte until deselect.
// - Status byte returned for every byte that carries no read data; bit 7 shows port ready.
// - One command per chip-select-low period; deselect ends the access.
module spimad_top (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic SPI_SCLK,
   input wire logic SPI_CS_N,
   input wire logic SPI_MOSI,
   output logic SPI_MISO,
   input wire logic PORT_READY,
   input wire logic [6:0] STATUS_LOW,
   output logic MEM_WE,
   output logic MEM_RE,
   output logic MEM_PROG,
   output logic [spimad_pkg::ADDR_W-1:0] MEM_ADDR,
   output logic [spimad_pkg::BYTE_W-1:0] MEM_WDATA,
   input wire logic [spimad_pkg::BYTE_W-1:0] MEM_RDATA
);
   // ==========================================
   // Pin synchronisers
   // SCLK must stay below about a tenth of CLK: sync delay plus the read turnaround fit in half a period.
   logic [2:0] sclk_s_q;
   logic [2:0] cs_s_q;
   logic [2:0] mosi_s_q;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sclk_s_q <= 3'h0;
         cs_s_q <= spimad_pkg::SYNC_RST;
         mosi_s_q <= 3'h0;
      end else begin
         sclk_s_q <= {sclk_s_q[1:0], SPI_SCLK};
         cs_s_q <= {cs_s_q[1:0], SPI_CS_N};
         mosi_s_q <= {mosi_s_q[1:0], SPI_MOSI};
      end
   end
   wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
   wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
   wire cs_fall = ~cs_s_q[1] & cs_s_q[2];
   wire selected = ~cs_s_q[1];
   wire mosi_bit = mosi_s_q[2];

   // ==========================================
   // Byte receiver
   logic [2:0] bit_cnt_q;
   logic [6:0] rx_q;
   logic first_q;
   wire byte_done = selected & sclk_rise & (bit_cnt_q == spimad_pkg::LAST_BIT);
   wire [7:0] rx_byte = {rx_q, mosi_bit};
   always_ff @(posedge CLK) begin
      if (!RST_N || !selected) begin
         bit_cnt_q <= 3'h0;
         rx_q <= 7'h00;
      end else if (sclk_rise) begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         rx_q <= rx_byte[6:0];
      end
   end

   // ==========================================
   // Command decode
   function automatic logic op_is(input logic [7:0] b, input logic [4:0] op);
      op_is = (b[spimad_pkg::CMD_OP_MSB:spimad_pkg::CMD_OP_LSB] == op);
   endfunction
   wire [2:0] hi_bits = rx_byte[2:0];
   wire hi_prog = (hi_bits == spimad_pkg::PROG_RAM_HI);
   wire is_seq_wr = op_is(rx_byte, spimad_pkg::OP_SEQ_WR);
   wire is_seq_rd = op_is(rx_byte, spimad_pkg::OP_SEQ_RD) & ~hi_prog;
   wire is_rnd_wr = op_is(rx_byte, spimad_pkg::OP_RND_WR) & ~hi_prog;
   wire is_rnd_rd = op_is(rx_byte, spimad_pkg::OP_RND_RD) & ~hi_prog;
   wire is_cmd = is_seq_wr | is_seq_rd | is_rnd_wr | is_rnd_rd;

   // ==========================================
   // Decoder state machine
   spimad_pkg::spimad_state_t state_q, state_d;
   spimad_pkg::spimad_kind_t kind_q;
   logic [spimad_pkg::ADDR_W-1:0] addr_q;
   logic prog_q;
   // State decode shared by the strobes and the address update
   wire st_idle = (state_q == spimad_pkg::SPIMAD_IDLE);
   wire st_addr = (state_q == spimad_pkg::SPIMAD_ADDR);
   wire st_seq_wr = (state_q == spimad_pkg::SPIMAD_SEQ_WR);
   wire st_seq_rd = (state_q == spimad_pkg::SPIMAD_SEQ_RD);
   wire st_rw_addr = (state_q == spimad_pkg::SPIMAD_RW_ADDR);
   wire st_rw_data = (state_q == spimad_pkg::SPIMAD_RW_DATA);
   wire st_rnd_rd = (state_q == spimad_pkg::SPIMAD_RND_RD);
   wire kind_rnd_rd = (kind_q == spimad_pkg::SPIMAD_K_RND_RD);
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         spimad_pkg::SPIMAD_IDLE: begin
            // Unknown codes and the no-operation byte leave only status flowing
            state_d = is_cmd ? spimad_pkg::SPIMAD_ADDR : spimad_pkg::SPIMAD_IGNORE;
         end
         spimad_pkg::SPIMAD_ADDR: begin
            unique case (kind_q)
               spimad_pkg::SPIMAD_K_SEQ_WR: state_d = spimad_pkg::SPIMAD_SEQ_WR;
               spimad_pkg::SPIMAD_K_SEQ_RD: state_d = spimad_pkg::SPIMAD_SEQ_RD;
               spimad_pkg::SPIMAD_K_RND_WR: state_d = spimad_pkg::SPIMAD_RW_DATA;
               spimad_pkg::SPIMAD_K_RND_RD: state_d = spimad_pkg::SPIMAD_RND_RD;
            endcase
         end
         spimad_pkg::SPIMAD_RW_ADDR: state_d = spimad_pkg::SPIMAD_RW_DATA;
         spimad_pkg::SPIMAD_RW_DATA: state_d = spimad_pkg::SPIMAD_RW_ADDR;
         spimad_pkg::SPIMAD_SEQ_WR, spimad_pkg::SPIMAD_SEQ_RD,
         spimad_pkg::SPIMAD_RND_RD, spimad_pkg::SPIMAD_IGNORE: state_d = state_q;
         default: state_d = spimad_pkg::SPIMAD_IGNORE;
      endcase
   end

   // Memory strobes issued at the end of a byte
   wire do_wr = byte_done & (st_seq_wr | st_rw_data);
   wire do_seq_rd = byte_done & st_seq_rd;
   // Random reads issue from the first address byte on, dummies too, to keep the two-byte pipe full
   wire do_rnd_rd = byte_done & ((st_addr & kind_rnd_rd) | st_rnd_rd);
   wire [spimad_pkg::ADDR_W-1:0] rnd_addr = {addr_q[10:8], rx_byte};
   // No block length cap: the address wraps at 11 bits and the host keeps to the block sizes
   wire [spimad_pkg::ADDR_W-1:0] addr_inc = addr_q + 11'h001;
   wire take_low = byte_done & (st_addr | st_rw_addr);
   wire do_inc = byte_done & (st_seq_wr | st_seq_rd);

   always_ff @(posedge CLK) begin
      if (!RST_N || !selected) begin
         state_q <= spimad_pkg::SPIMAD_IDLE;
         kind_q <= spimad_pkg::SPIMAD_K_SEQ_WR;
         addr_q <= 11'h000;
         prog_q <= 1'b0;
      end else if (byte_done) begin
         state_q <= state_d;
         if (st_idle) begin
            addr_q <= {hi_bits, 8'h00};
            prog_q <= is_seq_wr & hi_prog;
            kind_q <= is_seq_rd ? spimad_pkg::SPIMAD_K_SEQ_RD :
                      is_rnd_wr ? spimad_pkg::SPIMAD_K_RND_WR :
                      is_rnd_rd ? spimad_pkg::SPIMAD_K_RND_RD : spimad_pkg::SPIMAD_K_SEQ_WR;
         end else if (take_low) begin
            addr_q <= rnd_addr;
         end else if (do_inc) begin
            addr_q <= addr_inc;
         end
      end
   end

   // ==========================================
   // Memory port
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         MEM_WE <= 1'b0;
         MEM_RE <= 1'b0;
         MEM_PROG <= 1'b0;
         MEM_ADDR <= 11'h000;
         MEM_WDATA <= 8'h00;
      end else begin
         MEM_WE <= do_wr;
         MEM_RE <= do_seq_rd | do_rnd_rd;
         if (do_wr || do_seq_rd || do_rnd_rd) begin
            MEM_ADDR <= do_rnd_rd ? rnd_addr : addr_q;
            MEM_PROG <= prog_q;
            MEM_WDATA <= rx_byte;
         end
      end
   end

   // ==========================================
   // Transmit side
   // Read data is taken one cycle after the strobe and the next byte is loaded then.
   logic load_q;
   logic seq_load_q;
   logic rnd_load_q;
   logic pipe_ok_q;
   logic [7:0] pipe_q;
   logic [7:0] tx_q;
   // The fall after the last rise must not shift, or the freshly loaded byte loses its top bit
   wire tx_shift = selected & sclk_fall & (bit_cnt_q != 3'h0);
   wire [7:0] status_byte = {PORT_READY, STATUS_LOW};
   wire [7:0] load_byte = seq_load_q ? MEM_RDATA :
                          (rnd_load_q & pipe_ok_q) ? pipe_q : status_byte;
   always_ff @(posedge CLK) begin
      if (!RST_N || !selected) begin
         load_q <= 1'b0;
         seq_load_q <= 1'b0;
         rnd_load_q <= 1'b0;
      end else begin
         load_q <= byte_done;
         seq_load_q <= do_seq_rd;
         rnd_load_q <= do_rnd_rd;
      end
   end
   always_ff @(posedge CLK) begin
      if (!RST_N || !selected) begin
         pipe_q <= 8'h00;
         pipe_ok_q <= 1'b0;
      end else if (rnd_load_q) begin
         pipe_q <= MEM_RDATA;
         pipe_ok_q <= 1'b1;
      end
   end
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         tx_q <= 8'hFF;
      // Chip select fall reloads status ahead of any stale byte left from an aborted frame
      end else if (cs_fall) begin
         tx_q <= status_byte;
      end else if (load_q) begin
         tx_q <= load_byte;
      end else if (tx_shift) begin
         tx_q <= {tx_q[6:0], 1'b1};
      end
   end
   assign SPI_MISO = tx_q[spimad_pkg::STATUS_READY_BIT];
endmodule

// ==== testbench/spimad_monitor.sv ====
`timescale 1ns/1ps
// ==========
// Port checker
module spimad_monitor (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic SPI_CS_N,
   input wire logic SPI_MISO,
   input wire logic PORT_READY,
   input wire logic MEM_WE,
   input wire logic MEM_RE,
   input wire logic MEM_PROG,
   input wire logic [spimad_pkg::ADDR_W-1:0] MEM_ADDR
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // A byte spans many clocks, so two strobes never sit close together
   we_spacing_a: assert property (MEM_WE |=> !MEM_WE [*8]) else $error("write strobes too close");
   re_spacing_a: assert property (MEM_RE |=> !MEM_RE [*8]) else $error("read strobes too close");
   strobe_exclusive_a: assert property (!(MEM_WE && MEM_RE)) else $error("read and write together");
   prog_no_read_a: assert property (MEM_RE |-> !MEM_PROG) else $error("program memory read");
   idle_quiet_a: assert property (SPI_CS_N [*6] |-> !(MEM_WE || MEM_RE)) else $error("strobe when idle");
   strobe_framed_a: assert property ((MEM_WE || MEM_RE) |-> !SPI_CS_N) else $error("strobe off frame");
   addr_hold_a: assert property (!(MEM_WE || MEM_RE) |-> $stable(MEM_ADDR)) else $error("address moved");
   status_first_a: assert property ($fell(SPI_CS_N) |-> ##6 SPI_MISO == PORT_READY) else $error("no ready bit");
endmodule
bind spimad_top spimad_monitor u_mon (.CLK(CLK), .RST_N(RST_N), .SPI_CS_N(SPI_CS_N), .SPI_MISO(SPI_MISO),
   .PORT_READY(PORT_READY), .MEM_WE(MEM_WE), .MEM_RE(MEM_RE), .MEM_PROG(MEM_PROG), .MEM_ADDR(MEM_ADDR));

// ==== testbench/spimad_host.sv ====
`timescale 1ns/1ps
// ==========
// Host master, mode 0, eight system clocks per phase
module spimad_host (
   input wire logic clk,
   input wire logic miso,
   output logic sclk,
   output logic cs_n,
   output logic mosi
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b1;
   end
   task automatic open_frame();
      repeat (8) @(posedge clk);
      cs_n <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   // Released data line toggles so a stale level is never mistaken for data
   task automatic close_frame();
      repeat (8) @(posedge clk);
      cs_n <= 1'b1;
      mosi <= ~mosi;
      repeat (8) @(posedge clk);
   endtask
   task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
      rx = 8'hFF;
      for (int i = 7; i > 7 - nb; i--) begin
         mosi <= tx[i];
         repeat (8) @(posedge clk);
         sclk <= 1'b1;
         rx[i] = miso;
         repeat (8) @(posedge clk);
         sclk <= 1'b0;
      end
   endtask
endmodule

// ==== testbench/spi_memory_access_decoder_bench.sv ====
`timescale 1ns/1ps
module spi_memory_access_decoder_bench;
   logic clk = 1'b0, rst_n = 1'b0, rdy = 1'b1, sclk, cs_n, mosi, miso, we, re, prog;
   logic [6:0] low = 7'h12;
   logic [10:0] addr;
   logic [7:0] wd, rd, st, rx[$];
   logic [19:0] wq[$];
   int n_errors = 0, comparisons = 0;
   always #2 clk = ~clk;
   assign st = {rdy, low};
   assign rd = mem_f(addr);
   always @(posedge clk) if (we) wq.push_back({prog, addr, wd});
   spimad_top u_dut (.CLK(clk), .RST_N(rst_n), .SPI_SCLK(sclk), .SPI_CS_N(cs_n), .SPI_MOSI(mosi), .SPI_MISO(miso),
      .PORT_READY(rdy), .STATUS_LOW(low), .MEM_WE(we), .MEM_RE(re), .MEM_PROG(prog), .MEM_ADDR(addr),
      .MEM_WDATA(wd), .MEM_RDATA(rd));
   spimad_host u_host (.clk(clk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
   function automatic logic [7:0] mem_f(input logic [10:0] a);
      return ~a[7:0] ^ {a[10:8], 5'h00};
   endfunction
   task automatic check(input logic [19:0] got, input logic [19:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic frame(input logic [7:0] b[$], input int last_bits);
      logic [7:0] r;
      rx = {};
      wq = {};
      u_host.open_frame();
      foreach (b[i]) begin
         u_host.xfer(b[i], (i == b.size() - 1) ? last_bits : 8, r);
         rx.push_back(r);
      end
      u_host.close_frame();
   endtask
   // ==========
   // Scenarios
   task automatic seq_write();
      logic [7:0] c[4] = '{8'h18, 8'h19, 8'h1B, 8'h1E};
      foreach (c[k]) begin
         frame({c[k], 8'hFF, 8'h00, 8'hA5}, 8);
         check(wq.size(), 2);
         check(wq[0], {c[k] == 8'h1E, c[k][2:0], 8'hFF, 8'h00});
         check(wq[1], {c[k] == 8'h1E, c[k][2:0] + 3'h1, 8'h00, 8'hA5});
         check(rx[3], st);
      end
   endtask
   task automatic seq_read();
      logic [7:0] c[3] = '{8'h38, 8'h39, 8'h3B};
      foreach (c[k]) begin
         frame({c[k], 8'h5A, 8'hFF, 8'hFF, 8'hFF}, 8);
         check(rx[2], st);
         check(rx[3], mem_f({c[k][2:0], 8'h5A}));
         check(rx[4], mem_f({c[k][2:0], 8'h5B}));
      end
   endtask
   task automatic rnd_ops();
      logic [7:0] c[3] = '{8'h08, 8'h09, 8'h0B};
      foreach (c[k]) begin
         frame({c[k], 8'h10, 8'h3C, 8'h02, 8'hC3, 8'h77}, 8);
         check(wq.size(), 2);
         check(wq[0], {1'b0, c[k][2:0], 8'h10, 8'h3C});
         check(wq[1], {1'b0, c[k][2:0], 8'h02, 8'hC3});
         frame({c[k] | 8'h20, 8'h40, 8'h07, 8'hFF, 8'hFF}, 8);
         check(rx[3], mem_f({c[k][2:0], 8'h40}));
         check(rx[4], mem_f({c[k][2:0], 8'h07}));
      end
   endtask
   task automatic refused();
      @(posedge clk) rdy <= 1'b0;
      frame({8'hFF, 8'hFF}, 8);
      check(rx[1], st);
      @(posedge clk) rdy <= 1'b1;
      frame({8'h0E, 8'h00, 8'hFF, 8'hFF}, 8);
      check(wq.size(), 0);
      frame({8'h3E, 8'h00, 8'hFF, 8'hFF}, 8);
      check(rx[3], st);
   endtask
   task automatic abort();
      frame({8'h1B, 8'h20, 8'h99}, 4);
      check(wq.size(), 0);
      frame({8'h1B, 8'h21, 8'h66}, 8);
      check(wq[0], {1'b0, 3'h3, 8'h21, 8'h66});
   endtask
   task automatic conclude();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      seq_write();
      seq_read();
      rnd_ops();
      refused();
      abort();
      conclude();
   end
   // Whole run needs about 45 us; the limit leaves some threefold margin
   initial begin
      #150000;
      n_errors++;
      conclude();
   end
endmodule
